// *** prmi_rx.sv ***
/*
 Receive-side MAC interface: takes decoded symbols from the PHY core
 on clock and presents them to the MAC on the receive clock as MII,
 RMII or RGMII.
 Assumes the symbol source runs on clock and keeps pace with the
 receive clock, and that rx_link_clock is the clock that leaves the
 device as the receive clock (recovered or reference derived).
*/
`timescale 1ns/1ns

// Operation
// - Receive data outputs change on, and are meant to be sampled at, the receive clock rise.
// - Data lines carry meaning only while valid is high, so they are driven to zero otherwise.
// - In MII mode each received group appears as a nibble on data lines three to zero.
// - In RMII mode data appears two bits at a time on data lines one and zero only.
// - In RMII mode the valid output is the merged carrier-and-valid indication.
// - A repeater select input replaces the merged RMII indication with pure data valid.
// - In RGMII mode one control output carries both data valid and receive error.
// - In RGMII mode valid goes out at the rising receive clock edge and valid xor error at the falling.
// - The receive clock is 2.5 MHz recovered in MII and RGMII, 50 MHz in RMII master.
// - In MII and RMII every reception error raises receive error, idle errors included.
module prmi_rx
(
    input wire logic clock, // Core clock, 250 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic rx_link_clock, // Receive clock of the MAC side
    input wire logic [1:0] mode_sel, // Interface mode strap pins
    input wire logic repeater_sel, // Pure data valid in RMII when high
    input wire logic sym_valid, // Decoded symbol offered
    output logic sym_ready, // Symbol can be taken
    input wire logic [3:0] sym_data, // Decoded data group
    input wire logic sym_dv, // Symbol is frame data
    input wire logic sym_err, // Symbol is a reception error
    input wire logic sym_crs, // Carrier present
    output logic [3:0] rx_data, // Receive data lines
    output logic rx_dv, // MII valid or RMII CRS_DV
    output logic rx_er, // Receive error, MII and RMII
    output logic rx_ctrl_rise, // RGMII control, rising half
    output logic rx_ctrl_fall // RGMII control, falling half
);

    // ==========================================================
    // Mode decode
    // ==========================================================
    function automatic prmi_pkg::prmi_mode_t prmi_decode_mode(input logic [1:0] sel);
        prmi_pkg::prmi_mode_t m;
        m = prmi_pkg::RST_MODE;
        unique case (sel)
            prmi_pkg::MODE_SEL_MII: m = prmi_pkg::PRMI_MII;
            prmi_pkg::MODE_SEL_RMII: m = prmi_pkg::PRMI_RMII;
            prmi_pkg::MODE_SEL_RGMII: m = prmi_pkg::PRMI_RGMII;
            // Unused strap code falls back to MII
            default: m = prmi_pkg::PRMI_MII;
        endcase
        return m;
    endfunction

    // ==========================================================
    // Strap synchronisers and link reset
    // ==========================================================
    logic [2:0] strap_s;
    logic ack_s;
    logic req_s;
    logic link_rst_b;

    prmi_sync #(.WIDTH(3)) u_strap_sync
    (
        .clock(clock),
        .rst_b(rst_b),
        .d({repeater_sel, mode_sel}),
        .q(strap_s)
    );

    // Assert at once, release on the link clock
    prmi_sync #(.WIDTH(1)) u_link_rst_sync
    (
        .clock(rx_link_clock),
        .rst_b(rst_b),
        .d(1'b1),
        .q(link_rst_b)
    );

    // ==========================================================
    // Core side: symbol hold and request toggle
    // ==========================================================
    logic [3:0] hold_data_ff;
    logic hold_dv_ff;
    logic hold_err_ff;
    logic hold_crs_ff;
    prmi_pkg::prmi_mode_t hold_mode_ff;
    logic hold_rptr_ff;
    logic req_ff;
    logic ready_ff;
    logic frame_ff;
    prmi_pkg::prmi_mode_t mode_ff;
    logic rptr_ff;

    logic [3:0] nxt_hold_data;
    logic nxt_hold_dv;
    logic nxt_hold_err;
    logic nxt_hold_crs;
    prmi_pkg::prmi_mode_t nxt_hold_mode;
    logic nxt_hold_rptr;
    logic nxt_req;
    logic nxt_ready;
    logic nxt_frame;
    prmi_pkg::prmi_mode_t nxt_mode;
    logic nxt_rptr;
    logic take;

    always_comb
    begin
        take = sym_valid & ready_ff;
        nxt_hold_data = hold_data_ff;
        nxt_hold_dv = hold_dv_ff;
        nxt_hold_err = hold_err_ff;
        nxt_hold_crs = hold_crs_ff;
        nxt_hold_mode = hold_mode_ff;
        nxt_hold_rptr = hold_rptr_ff;
        nxt_frame = frame_ff;
        nxt_mode = mode_ff;
        nxt_rptr = rptr_ff;
        // Mode only follows the straps between frames
        if (!frame_ff)
        begin
            nxt_mode = prmi_decode_mode(strap_s[1:0]);
            nxt_rptr = strap_s[2];
        end
        if (take)
        begin
            nxt_hold_data = sym_data;
            nxt_hold_dv = sym_dv;
            nxt_hold_err = sym_err;
            nxt_hold_crs = sym_crs;
            nxt_hold_mode = mode_ff;
            nxt_hold_rptr = rptr_ff;
            nxt_frame = sym_dv | sym_crs;
        end
        nxt_req = req_ff ^ take;
        // Ack only ever catches up, so a stale ready never overruns
        nxt_ready = (nxt_req == ack_s);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_data_ff <= prmi_pkg::RST_DATA;
            hold_dv_ff <= prmi_pkg::RST_BIT;
            hold_err_ff <= prmi_pkg::RST_BIT;
            hold_crs_ff <= prmi_pkg::RST_BIT;
            hold_mode_ff <= prmi_pkg::RST_MODE;
            hold_rptr_ff <= prmi_pkg::RST_BIT;
            req_ff <= prmi_pkg::RST_BIT;
            ready_ff <= prmi_pkg::RST_BIT;
            frame_ff <= prmi_pkg::RST_BIT;
            mode_ff <= prmi_pkg::RST_MODE;
            rptr_ff <= prmi_pkg::RST_BIT;
        end
        else
        begin
            hold_data_ff <= nxt_hold_data;
            hold_dv_ff <= nxt_hold_dv;
            hold_err_ff <= nxt_hold_err;
            hold_crs_ff <= nxt_hold_crs;
            hold_mode_ff <= nxt_hold_mode;
            hold_rptr_ff <= nxt_hold_rptr;
            req_ff <= nxt_req;
            ready_ff <= nxt_ready;
            frame_ff <= nxt_frame;
            mode_ff <= nxt_mode;
            rptr_ff <= nxt_rptr;
        end
    end

    assign sym_ready = ready_ff;

    // ==========================================================
    // Handshake crossing
    // ==========================================================
    logic seen_ff;

    prmi_sync #(.WIDTH(1)) u_req_sync
    (
        .clock(rx_link_clock),
        .rst_b(link_rst_b),
        .d(req_ff),
        .q(req_s)
    );

    prmi_sync #(.WIDTH(1)) u_ack_sync
    (
        .clock(clock),
        .rst_b(rst_b),
        .d(seen_ff),
        .q(ack_s)
    );

    // ==========================================================
    // Link side: MAC facing outputs on the receive clock
    // ==========================================================
    logic [3:0] data_ff;
    logic dv_ff;
    logic er_ff;
    logic rise_ff;
    logic rg_err_ff;
    logic fall_ff;

    logic nxt_seen;
    logic [3:0] nxt_data;
    logic nxt_dv;
    logic nxt_er;
    logic nxt_rise;
    logic nxt_rg_err;
    logic nxt_fall;
    logic fresh;
    logic w_dv;
    logic w_err;
    logic w_crs;
    logic [3:0] w_data;

    always_comb
    begin
        // Hold registers are stable from request until acknowledge
        fresh = (req_s != seen_ff);
        nxt_seen = seen_ff ^ fresh;
        // Starved cycle goes out as idle
        w_dv = fresh & hold_dv_ff;
        w_err = fresh & hold_err_ff;
        w_crs = fresh & hold_crs_ff;
        w_data = w_dv ? hold_data_ff : prmi_pkg::RST_DATA;
        nxt_data = prmi_pkg::RST_DATA;
        nxt_dv = prmi_pkg::RST_BIT;
        nxt_er = prmi_pkg::RST_BIT;
        nxt_rise = prmi_pkg::RST_BIT;
        nxt_rg_err = prmi_pkg::RST_BIT;
        unique case (hold_mode_ff)
            prmi_pkg::PRMI_MII:
            begin
                nxt_data = w_data;
                nxt_dv = w_dv;
                nxt_er = w_err;
            end
            prmi_pkg::PRMI_RMII:
            begin
                nxt_data = {2'h0, w_data[prmi_pkg::RMII_W-1:0]};
                nxt_dv = hold_rptr_ff ? w_dv : (w_dv | w_crs);
                nxt_er = w_err;
            end
            prmi_pkg::PRMI_RGMII:
            begin
                nxt_data = w_data;
                nxt_rise = w_dv;
                nxt_rg_err = w_err;
            end
        endcase
        // Falling half follows the RGMII encoding of valid xor error
        nxt_fall = rise_ff ^ rg_err_ff;
    end

    // Link clock is the outgoing receive clock, so outputs move on its rise
    always_ff @(posedge rx_link_clock or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            seen_ff <= prmi_pkg::RST_BIT;
            data_ff <= prmi_pkg::RST_DATA;
            dv_ff <= prmi_pkg::RST_BIT;
            er_ff <= prmi_pkg::RST_BIT;
            rise_ff <= prmi_pkg::RST_BIT;
            rg_err_ff <= prmi_pkg::RST_BIT;
        end
        else
        begin
            seen_ff <= nxt_seen;
            data_ff <= nxt_data;
            dv_ff <= nxt_dv;
            er_ff <= nxt_er;
            rise_ff <= nxt_rise;
            rg_err_ff <= nxt_rg_err;
        end
    end

    // Falling-edge half of the double data rate control line
    always_ff @(negedge rx_link_clock or negedge link_rst_b)
    begin
        if (!link_rst_b)
        begin
            fall_ff <= prmi_pkg::RST_BIT;
        end
        else
        begin
            fall_ff <= nxt_fall;
        end
    end

    assign rx_data = data_ff;
    assign rx_dv = dv_ff;
    assign rx_er = er_ff;
    assign rx_ctrl_rise = rise_ff;
    assign rx_ctrl_fall = fall_ff;

endmodule

// *** prmi_pkg.sv ***
/*
 Shared constants and types of the receive-side MAC interface block.
 Assumes nothing of its surroundings; included by compile order only.
*/
package prmi_pkg;

    // ==========================================================
    // Interface modes
    // ==========================================================
    typedef enum logic [1:0] {PRMI_MII, PRMI_RMII, PRMI_RGMII} prmi_mode_t;

    // Encodings on the mode strap pins
    localparam logic [1:0] MODE_SEL_MII = 2'h0;
    localparam logic [1:0] MODE_SEL_RMII = 2'h1;
    localparam logic [1:0] MODE_SEL_RGMII = 2'h2;

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int DATA_W = 4;
    localparam int RMII_W = 2;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [3:0] RST_DATA = 4'h0;
    localparam logic RST_BIT = 1'b0;
    localparam prmi_mode_t RST_MODE = PRMI_MII;

    // ==========================================================
    // Clock figures (kept for reference by the system)
    // ==========================================================
    localparam int REF_MII_HZ = 25_000_000;
    localparam int REF_RMII_SLAVE_HZ = 50_000_000;
    localparam int RXCLK_10M_HZ = 2_500_000;
    localparam int RMII_MASTER_CLK_HZ = 50_000_000;

endpackage

// *** prmi_sync.sv ***
/*
 Two-flop synchroniser with asynchronous active-low reset.
 Assumes d is a level, or a toggle that changes at most once per
 several destination clocks.
*/
`timescale 1ns/1ns
module prmi_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clock, // Destination clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [WIDTH-1:0] d, // Level from another domain
    output logic [WIDTH-1:0] q // Synchronised level
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] q_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_q;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        nxt_stage1 = d;
        nxt_q = stage1_ff;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            stage1_ff <= nxt_stage1;
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule

// *** prmi_rx_assertions.sv ***
/*
 Port checker for prmi_rx, bound to every instance.
 Assumes straps change only between frames.
*/
`timescale 1ns/1ns
module prmi_rx_chk
(
    input wire logic clock, // Core clock
    input wire logic rst_b, // Async reset, active low
    input wire logic rx_link_clock, // Receive clock
    input wire logic [1:0] mode_sel, // Mode straps
    input wire logic sym_valid, // Symbol offered
    input wire logic sym_ready, // Symbol can be taken
    input wire logic [3:0] rx_data, // Receive data lines
    input wire logic rx_dv, // Valid or merged carrier
    input wire logic rx_er, // Receive error
    input wire logic rx_ctrl_rise, // Control, rising half
    input wire logic rx_ctrl_fall // Control, falling half
);
    // ==========
    // Link side
    // ==========
    a_data_idle_zero: assert property (@(posedge rx_link_clock) disable iff (!rst_b)
        !rx_dv && !rx_ctrl_rise |-> rx_data == 4'h0) else $error("data not zero outside valid");
    a_rmii_upper_zero: assert property (@(posedge rx_link_clock) disable iff (!rst_b)
        mode_sel == 2'h1 && $past(mode_sel, 3) == 2'h1 |-> rx_data[3:2] == 2'h0)
        else $error("upper data lines driven in RMII");
    a_rgmii_mii_quiet: assert property (@(posedge rx_link_clock) disable iff (!rst_b)
        mode_sel == 2'h2 && $past(mode_sel, 3) == 2'h2 |-> !rx_dv && !rx_er)
        else $error("valid or error driven in RGMII");
    a_ctrl_rise_quiet: assert property (@(posedge rx_link_clock) disable iff (!rst_b)
        mode_sel != 2'h2 && $past(mode_sel, 3) != 2'h2 |-> !rx_ctrl_rise)
        else $error("control driven outside RGMII");
    a_ctrl_fall_quiet: assert property (@(negedge rx_link_clock) disable iff (!rst_b)
        mode_sel != 2'h2 && $past(mode_sel, 3) != 2'h2 |-> !rx_ctrl_fall)
        else $error("falling control driven outside RGMII");
    // ==========
    // Edge placement and ready handshake, seen from the core clock
    // ==========
    a_data_on_rise: assert property (@(posedge clock) disable iff (!rst_b)
        $changed({rx_data, rx_dv, rx_er, rx_ctrl_rise}) |-> rx_link_clock)
        else $error("receive outputs moved off the rising edge");
    a_fall_on_fall: assert property (@(posedge clock) disable iff (!rst_b)
        $changed(rx_ctrl_fall) |-> !rx_link_clock) else $error("falling half moved off fall");
    a_ready_drops: assert property (@(posedge clock) disable iff (!rst_b)
        sym_valid && sym_ready |=> !sym_ready [*6]) else $error("ready did not drop after take");
    a_ready_returns: assert property (@(posedge clock) disable iff (!rst_b)
        sym_valid && sym_ready |-> ##[1:40] sym_ready) else $error("ready did not return");
endmodule

bind prmi_rx prmi_rx_chk u_chk (.clock(clock), .rst_b(rst_b), .rx_link_clock(rx_link_clock),
    .mode_sel(mode_sel), .sym_valid(sym_valid), .sym_ready(sym_ready), .rx_data(rx_data),
    .rx_dv(rx_dv), .rx_er(rx_er), .rx_ctrl_rise(rx_ctrl_rise), .rx_ctrl_fall(rx_ctrl_fall));

// *** prmi_mac_model.sv ***
/*
 MAC receive model: samples the receive lines at the receive clock rise.
 Assumes an idle cycle follows each active one.
*/
`timescale 1ns/1ns
module prmi_mac_model
(
    input wire logic rx_link_clock, // Receive clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [3:0] rx_data, // Receive data lines
    input wire logic rx_dv, // Valid or merged carrier
    input wire logic rx_er, // Receive error
    input wire logic rx_ctrl_rise, // Control, rising half
    input wire logic rx_ctrl_fall, // Control, falling half
    output logic [7:0] got, // Data, dv, er, rise, fall
    output logic [7:0] seen // Count of active cycles
);
    logic act;
    logic [3:0] vdata;
    assign act = rx_dv | rx_er | rx_ctrl_rise;
    // Data outside valid is noise to a MAC
    assign vdata = rx_data & {4{rx_dv | rx_ctrl_rise}};
    // ==========
    // Sampling
    // ==========
    always @(posedge rx_link_clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seen <= 8'h00;
            got <= 8'h00;
        end
        else if (act)
        begin
            // Falling half of this cycle has already landed by this rise
            got <= {vdata, rx_dv, rx_er, rx_ctrl_rise, rx_ctrl_fall};
            seen <= seen + 8'h01;
        end
    end
endmodule

// *** prmi_tb.sv ***
/*
 Testbench for prmi_rx: symbols in on the core clock, MAC model out.
 Assumes the bound checker and prmi_mac_model are compiled.
*/
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0;
    logic rx_link_clock = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic repeater_sel = 1'b0;
    logic sym_valid = 1'b0;
    logic sym_ready;
    logic [3:0] sym_data = 4'h0;
    logic sym_dv = 1'b0;
    logic sym_err = 1'b0;
    logic sym_crs = 1'b0;
    logic [3:0] rx_data;
    logic rx_dv;
    logic rx_er;
    logic rx_ctrl_rise;
    logic rx_ctrl_fall;
    logic [7:0] got;
    logic [7:0] seen;
    int n_fail = 0;
    int cmp_count = 0;

    always #2 clock = ~clock;
    // Odd offset keeps the link edges apart from core edges
    // Stands in for the system supplied clock, scaled for run time
    initial
    begin
        #5;
        forever #6 rx_link_clock = ~rx_link_clock;
    end

    prmi_rx u_dut (.clock(clock), .rst_b(rst_b), .rx_link_clock(rx_link_clock),
        .mode_sel(mode_sel), .repeater_sel(repeater_sel), .sym_valid(sym_valid),
        .sym_ready(sym_ready), .sym_data(sym_data), .sym_dv(sym_dv), .sym_err(sym_err),
        .sym_crs(sym_crs), .rx_data(rx_data), .rx_dv(rx_dv), .rx_er(rx_er),
        .rx_ctrl_rise(rx_ctrl_rise), .rx_ctrl_fall(rx_ctrl_fall));
    prmi_mac_model u_mac (.rx_link_clock(rx_link_clock), .rst_b(rst_b), .rx_data(rx_data),
        .rx_dv(rx_dv), .rx_er(rx_er), .rx_ctrl_rise(rx_ctrl_rise),
        .rx_ctrl_fall(rx_ctrl_fall), .got(got), .seen(seen));

    // ==========
    // Shared tasks
    // ==========
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic set_mode(input logic [1:0] m, input logic r);
        mode_sel <= m;
        repeater_sel <= r;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic send(input logic [3:0] d, input logic v, input logic e, input logic c);
        int n;
        n = 0;
        {sym_data, sym_dv, sym_err, sym_crs, sym_valid} <= {d, v, e, c, 1'b1};
        while (sym_ready !== 1'b1 && n < 100)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 100)
        begin
            n_fail++;
            complete_run();
        end
        @(posedge clock);
        #1;
        sym_valid <= 1'b0;
        // One idle edge before a following request raises valid again
        @(posedge clock);
        #1;
    endtask

    // Got is {data, dv, er, rise, fall}
    task automatic xfer(input logic [3:0] d, input logic v, input logic e, input logic c,
                        input logic [7:0] exp);
        logic [7:0] start;
        int n;
        start = seen;
        n = 0;
        send(d, v, e, c);
        while (seen === start && n < 40)
        begin
            @(posedge rx_link_clock);
            n++;
        end
        @(posedge clock);
        #1;
        cmp_count++;
        if (n >= 40 || got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            if (n >= 40)
                complete_run();
        end
    endtask

    // ==========
    // Scenarios
    // ==========
    task automatic t_mii();
        // Unused strap code behaves as MII
        set_mode(2'h3, 1'b0);
        xfer(4'hB, 1'b1, 1'b0, 1'b0, 8'hB8);
        set_mode(2'h0, 1'b0);
        xfer(4'hA, 1'b1, 1'b0, 1'b1, 8'hA8);
        xfer(4'h5, 1'b0, 1'b1, 1'b0, 8'h04);
        $display("t_mii done");
    endtask

    task automatic t_rmii();
        set_mode(2'h1, 1'b0);
        xfer(4'hF, 1'b1, 1'b0, 1'b1, 8'h38);
        xfer(4'h2, 1'b0, 1'b0, 1'b1, 8'h08);
        xfer(4'h9, 1'b0, 1'b1, 1'b0, 8'h04);
        $display("t_rmii done");
    endtask

    task automatic t_rep();
        set_mode(2'h1, 1'b1);
        xfer(4'h6, 1'b1, 1'b0, 1'b1, 8'h28);
        xfer(4'h0, 1'b0, 1'b1, 1'b1, 8'h04);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        $display("t_rep done");
    endtask

    task automatic t_freeze();
        set_mode(2'h1, 1'b0);
        xfer(4'hD, 1'b1, 1'b0, 1'b1, 8'h18);
        set_mode(2'h0, 1'b0);
        xfer(4'hD, 1'b1, 1'b0, 1'b1, 8'h18);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        xfer(4'hD, 1'b1, 1'b0, 1'b1, 8'hD8);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        $display("t_freeze done");
    endtask

    task automatic t_rgmii();
        set_mode(2'h2, 1'b0);
        xfer(4'hC, 1'b1, 1'b0, 1'b1, 8'hC3);
        xfer(4'h7, 1'b1, 1'b1, 1'b1, 8'h72);
        send(4'h0, 1'b0, 1'b0, 1'b0);
        $display("t_rgmii done");
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        #1;
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        t_mii();
        t_rmii();
        t_rep();
        t_freeze();
        t_rgmii();
        complete_run();
    end
endmodule
